// [logic/tsp_pkg.sv]
// tsp_pkg: constants, time figures and mode types of the time sync block.
// assumes a single 10 MHz system clock; no registers reachable by software.
package tsp_pkg;

	// --------------------------------------------------------------------
	// clock and time figures
	// --------------------------------------------------------------------
	localparam int CLK_KHZ     = 10000;	// 10 MHz system clock
	localparam int SEC_MS      = 1000;	// one second
	localparam int PULSE_MS    = 100;	// time pulse high time, 10 % duty
	localparam int MARK_MAX_HZ = 5;		// fastest time mark rate allowed
	localparam int MARK_GAP_MS = SEC_MS / MARK_MAX_HZ;

	// --------------------------------------------------------------------
	// widths and fixed numbers
	// --------------------------------------------------------------------
	localparam int SUB_W = 24;			// sub-second cycle counter
	localparam int SEC_W = 32;			// whole seconds
	localparam int PORT_W = 16;
	localparam logic [PORT_W-1:0] NTP_UDP_PORT = 16'h007b;	// 123
	localparam logic [PORT_W-1:0] RAW_RX_PORT  = 16'h4e2a;	// 20010

	// --------------------------------------------------------------------
	// modes and sources
	// --------------------------------------------------------------------
	typedef enum logic [1:0] {
		PROF_E2E,
		PROF_GPTP,
		PROF_AUTO
	} tsp_profile_t;

	typedef enum logic [1:0] {
		SRC_INTERNAL,
		SRC_ITS,
		SRC_SAT
	} tsp_src_t;

endpackage

// [logic/tsp_pin_sync.sv]
// tsp_pin_sync: two-flop synchroniser for a pin with rising edge pulse.
// assumes the pin is asynchronous to clk_i; pulse lags the pin by 2 edges.
`timescale 1ns/1ps
module tsp_pin_sync (
	input  wire logic clk_i,	// system clock
	input  wire logic rst_i,	// async reset, active high
	input  wire logic pin_i,	// raw pin level
	output logic      rise_o	// one-cycle pulse on rising edge
);
	logic meta;
	logic stable;
	logic last;

	// meta is read only by stable
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta   <= 1'b0;
			stable <= 1'b0;
			last   <= 1'b0;
		end else begin
			meta   <= pin_i;
			stable <= meta;
			last   <= stable;
		end
	end

	assign rise_o = stable & ~last;
endmodule

// [logic/tsp_time_sync.sv]
// tsp_time_sync: system time base, source selection, time pulse, time mark,
// and the timing hooks of the ntp server and ptp grand master.
// assumes packet framing lives elsewhere and uses the strobes seen here.
`timescale 1ns/1ps
module tsp_time_sync #(
	parameter logic [tsp_pkg::SUB_W-1:0] CYC_PER_SEC  =
		tsp_pkg::SUB_W'(tsp_pkg::SEC_MS * tsp_pkg::CLK_KHZ),
	parameter logic [tsp_pkg::SUB_W-1:0] PULSE_CYC    =
		tsp_pkg::SUB_W'(tsp_pkg::PULSE_MS * tsp_pkg::CLK_KHZ),
	parameter logic [tsp_pkg::SUB_W-1:0] MARK_GAP_CYC =
		tsp_pkg::SUB_W'(tsp_pkg::MARK_GAP_MS * tsp_pkg::CLK_KHZ)
) (
	input  wire logic                        SYS_CLK_I,        // 10 MHz clock
	input  wire logic                        RST_I,            // async reset
	input  wire logic                        SAT_PPS_I,        // receiver pulse pin
	input  wire logic                        SAT_VALID_I,      // receiver time valid
	input  wire logic [tsp_pkg::SEC_W-1:0]   SAT_SEC_I,        // second at edge
	input  wire logic                        NET_UP_I,         // internet reachable
	input  wire logic                        ITS_SET_I,        // its fix strobe
	input  wire logic [tsp_pkg::SEC_W-1:0]   ITS_SEC_I,        // its second
	input  wire logic                        TMARK_I,          // time mark pin
	input  wire logic                        NTP_EN_I,         // ntp server on
	input  wire logic                        NTP_REQ_I,        // ntp request strobe
	input  wire logic                        PTP_EN_I,         // ptp on
	input  wire logic [1:0]                  PTP_PROFILE_I,    // ptp profile
	input  wire logic                        PTP_DELAY_REQ_I,  // delay req strobe
	output logic [1:0]                       TIME_SRC_O,       // active source
	output logic                             HOLDOVER_O,       // sat lost, free run
	output logic [tsp_pkg::SEC_W-1:0]        TIME_SEC_O,       // system seconds
	output logic [tsp_pkg::SUB_W-1:0]        TIME_SUB_O,       // sub-second cycles
	output logic                             ITS_REQ_O,        // ask for its fix
	output logic                             PPS_O,            // time pulse pin
	output logic                             PPS_TS_VALID_O,   // pulse timestamp
	output logic [tsp_pkg::SEC_W-1:0]        PPS_TS_SEC_O,     // second of pulse
	output logic                             MARK_TS_VALID_O,  // mark timestamp
	output logic [tsp_pkg::SEC_W-1:0]        MARK_TS_SEC_O,    // mark second
	output logic [tsp_pkg::SUB_W-1:0]        MARK_TS_SUB_O,    // mark sub-second
	output logic                             MARK_DROP_O,      // mark too soon
	output logic [tsp_pkg::PORT_W-1:0]       RAW_PORT_O,       // timestamp port
	output logic [tsp_pkg::PORT_W-1:0]       NTP_PORT_O,       // ntp udp port
	output logic                             NTP_ANS_VALID_O,  // ntp answer
	output logic [tsp_pkg::SEC_W-1:0]        NTP_ANS_SEC_O,    // answer second
	output logic [tsp_pkg::SUB_W-1:0]        NTP_ANS_SUB_O,    // answer sub
	output logic                             PTP_SYNC_O,       // send sync
	output logic [tsp_pkg::SEC_W-1:0]        PTP_SYNC_SEC_O,   // sync origin sec
	output logic                             PTP_DELAY_RESP_O, // send delay resp
	output logic [tsp_pkg::SEC_W-1:0]        PTP_DELAY_SEC_O,  // receive second
	output logic [tsp_pkg::SUB_W-1:0]        PTP_DELAY_SUB_O,  // receive sub
	output logic                             PTP_BMCA_EN_O,    // best master on
	output logic                             GRAND_MASTER_ROLE_O // acting master
);
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);

	// --------------------------------------------------------------------
	// pins
	// --------------------------------------------------------------------
	logic sat_rise;
	logic mark_rise;
	tsp_pin_sync u_sat_sync (.clk_i(SYS_CLK_I), .rst_i(RST_I), .pin_i(SAT_PPS_I),
		.rise_o(sat_rise));
	tsp_pin_sync u_mark_sync (.clk_i(SYS_CLK_I), .rst_i(RST_I), .pin_i(TMARK_I),
		.rise_o(mark_rise));

	// --------------------------------------------------------------------
	// time base and source
	// --------------------------------------------------------------------
	logic [tsp_pkg::SUB_W-1:0] sub;
	logic [tsp_pkg::SUB_W-1:0] next_sub;
	logic [tsp_pkg::SEC_W-1:0] sec;
	logic [tsp_pkg::SEC_W-1:0] next_sec;
	tsp_pkg::tsp_src_t         src;
	tsp_pkg::tsp_src_t         next_src;
	logic                      sat_align;
	logic                      its_load;
	logic                      ptp_active;

	assign sat_align  = sat_rise & SAT_VALID_I;
	assign its_load   = ITS_SET_I & (src != tsp_pkg::SRC_SAT);
	assign ptp_active = PTP_EN_I & (PTP_PROFILE_I != 2'h3);

	always_comb begin
		next_sub = sub + 24'h1;
		next_sec = sec;
		next_src = src;
		if (sub >= CYC_PER_SEC - 24'h1) begin
			next_sub = '0;
			next_sec = sec + 32'h1;
		end
		// its is ignored once satellite owns the time
		if (its_load) begin
			next_sec = ITS_SEC_I;
			next_sub = '0;
			next_src = tsp_pkg::SRC_ITS;
		end
		// edge without valid time is noise from a degraded fix
		if (sat_align) begin
			next_sec = SAT_SEC_I;
			next_sub = '0;
			next_src = tsp_pkg::SRC_SAT;
		end
	end
	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sub <= '0;
			sec <= '0;
			src <= tsp_pkg::SRC_INTERNAL;
		end else begin
			sub <= next_sub;
			sec <= next_sec;
			src <= next_src;
		end
	end

	assign TIME_SEC_O = sec;
	assign TIME_SUB_O = sub;
	assign TIME_SRC_O = src;
	property p_sat_wins;
		sat_align |=> src == tsp_pkg::SRC_SAT && sub == '0 && sec == $past(SAT_SEC_I);
	endproperty
	a_sat_wins: assert property (p_sat_wins) else $error("sat edge did not align");
	property p_its_locked_out;
		src == tsp_pkg::SRC_SAT |=> src == tsp_pkg::SRC_SAT;
	endproperty
	a_its_locked_out: assert property (p_its_locked_out) else $error("source left sat");
	property p_sec_step;
		sub == CYC_PER_SEC - 24'h1 && !its_load && !sat_align
			|=> sec == $past(sec) + 32'h1 && sub == '0;
	endproperty
	a_sec_step: assert property (p_sec_step) else $error("second did not step");

	// --------------------------------------------------------------------
	// time pulse and per-second messages
	// --------------------------------------------------------------------
	logic                      pps;
	logic                      next_pps;
	logic                      pps_edge;
	logic                      pps_ts_valid;
	logic [tsp_pkg::SEC_W-1:0] pps_ts_sec;
	logic                      ptp_sync;
	logic [tsp_pkg::SEC_W-1:0] ptp_sync_sec;
	logic                      its_req;
	logic                      next_its_req;
	logic                      holdover;
	logic                      next_holdover;

	always_comb begin
		// starts only at a second boundary, so no stub after reset; realign stretches
		next_pps      = (next_sub < PULSE_CYC) & (pps | (next_sub == '0));
		pps_edge      = next_pps & ~pps;
		next_its_req  = NET_UP_I & (src == tsp_pkg::SRC_INTERNAL);
		next_holdover = (src == tsp_pkg::SRC_SAT) & ~SAT_VALID_I;
	end
	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			pps          <= 1'b0;
			pps_ts_valid <= 1'b0;
			pps_ts_sec   <= '0;
			ptp_sync     <= 1'b0;
			ptp_sync_sec <= '0;
			its_req      <= 1'b0;
			holdover     <= 1'b0;
		end else begin
			pps          <= next_pps;
			pps_ts_valid <= pps_edge;
			// sync keeps flowing in holdover: slaves stay mutually precise
			ptp_sync     <= pps_edge & ptp_active;
			its_req      <= next_its_req;
			holdover     <= next_holdover;
			if (pps_edge) begin
				pps_ts_sec   <= next_sec;
				ptp_sync_sec <= next_sec;
			end
		end
	end

	assign PPS_O          = pps;
	assign PPS_TS_VALID_O = pps_ts_valid;
	assign PPS_TS_SEC_O   = pps_ts_sec;
	assign PTP_SYNC_O     = ptp_sync;
	assign PTP_SYNC_SEC_O = ptp_sync_sec;
	assign ITS_REQ_O      = its_req;
	assign HOLDOVER_O     = holdover;
	assign RAW_PORT_O     = tsp_pkg::RAW_RX_PORT;
	property p_pps_on_second;
		$rose(pps) |-> sub == '0 && pps_ts_valid && pps_ts_sec == sec;
	endproperty
	a_pps_on_second: assert property (p_pps_on_second) else $error("pulse off second");
	property p_pps_width;
		$rose(pps) |-> pps[*8];
	endproperty
	a_pps_width: assert property (p_pps_width) else $error("pulse too short");
	property p_pps_end;
		pps && sub == PULSE_CYC - 24'h1 && !its_load && !sat_align |=> !pps;
	endproperty
	a_pps_end: assert property (p_pps_end) else $error("pulse too long");
	property p_sync_each_pulse;
		$rose(pps) |-> ptp_sync == $past(ptp_active);
	endproperty
	a_sync_each_pulse: assert property (p_sync_each_pulse) else $error("sync missed");

	// --------------------------------------------------------------------
	// time mark capture
	// --------------------------------------------------------------------
	logic [tsp_pkg::SUB_W-1:0] mark_gap;
	logic [tsp_pkg::SUB_W-1:0] next_mark_gap;
	logic                      mark_take;
	logic                      mark_valid;
	logic [tsp_pkg::SEC_W-1:0] mark_sec;
	logic [tsp_pkg::SUB_W-1:0] mark_sub;
	logic                      mark_drop;

	always_comb begin
		// guard against an outside party breaking the 5 Hz limit
		mark_take     = mark_rise & (mark_gap == '0);
		next_mark_gap = (mark_gap == '0) ? mark_gap : mark_gap - 24'h1;
		if (mark_take) begin
			next_mark_gap = MARK_GAP_CYC - 24'h1;
		end
	end
	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			mark_gap   <= '0;
			mark_valid <= 1'b0;
			mark_sec   <= '0;
			mark_sub   <= '0;
			mark_drop  <= 1'b0;
		end else begin
			mark_gap   <= next_mark_gap;
			mark_valid <= mark_take;
			mark_drop  <= mark_rise & ~mark_take;
			if (mark_take) begin
				mark_sec <= sec;
				mark_sub <= sub;
			end
		end
	end

	assign MARK_TS_VALID_O = mark_valid;
	assign MARK_TS_SEC_O   = mark_sec;
	assign MARK_TS_SUB_O   = mark_sub;
	assign MARK_DROP_O     = mark_drop;
	property p_mark_capture;
		mark_take |=> mark_valid && mark_sub == $past(sub) && mark_sec == $past(sec);
	endproperty
	a_mark_capture: assert property (p_mark_capture) else $error("mark not captured");

	// --------------------------------------------------------------------
	// ntp and ptp answers
	// --------------------------------------------------------------------
	logic                      ntp_valid;
	logic                      next_ntp_valid;
	logic [tsp_pkg::SEC_W-1:0] ntp_sec;
	logic [tsp_pkg::SUB_W-1:0] ntp_sub;
	logic                      dly_valid;
	logic                      next_dly_valid;
	logic [tsp_pkg::SEC_W-1:0] dly_sec;
	logic [tsp_pkg::SUB_W-1:0] dly_sub;

	always_comb begin
		// ntp stays silent until a precise source has set the time
		next_ntp_valid = NTP_REQ_I & NTP_EN_I & (src != tsp_pkg::SRC_INTERNAL);
		next_dly_valid = PTP_DELAY_REQ_I & ptp_active
			& (PTP_PROFILE_I == tsp_pkg::PROF_E2E);
	end
	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ntp_valid <= 1'b0;
			ntp_sec   <= '0;
			ntp_sub   <= '0;
			dly_valid <= 1'b0;
			dly_sec   <= '0;
			dly_sub   <= '0;
		end else begin
			ntp_valid <= next_ntp_valid;
			dly_valid <= next_dly_valid;
			if (next_ntp_valid) begin
				ntp_sec <= sec;
				ntp_sub <= sub;
			end
			if (next_dly_valid) begin
				dly_sec <= sec;
				dly_sub <= sub;
			end
		end
	end

	assign NTP_ANS_VALID_O  = ntp_valid;
	assign NTP_ANS_SEC_O    = ntp_sec;
	assign NTP_ANS_SUB_O    = ntp_sub;
	assign NTP_PORT_O       = tsp_pkg::NTP_UDP_PORT;
	assign PTP_DELAY_RESP_O = dly_valid;
	assign PTP_DELAY_SEC_O  = dly_sec;
	assign PTP_DELAY_SUB_O  = dly_sub;
	// master only: no path exists by which incoming time could steer sec
	assign GRAND_MASTER_ROLE_O = ptp_active;
	assign PTP_BMCA_EN_O = ptp_active & (PTP_PROFILE_I == tsp_pkg::PROF_GPTP);
	property p_ntp_answer;
		NTP_REQ_I |=> ntp_valid == $past(NTP_EN_I && src != tsp_pkg::SRC_INTERNAL);
	endproperty
	a_ntp_answer: assert property (p_ntp_answer) else $error("ntp answer wrong");
	property p_delay_resp;
		PTP_DELAY_REQ_I |=> dly_valid == $past(ptp_active
			&& PTP_PROFILE_I == tsp_pkg::PROF_E2E) && (!dly_valid || dly_sub == $past(sub));
	endproperty
	a_delay_resp: assert property (p_delay_resp) else $error("delay resp wrong");
	property p_auto_static;
		PTP_PROFILE_I == tsp_pkg::PROF_AUTO |-> !PTP_BMCA_EN_O;
	endproperty
	a_auto_static: assert property (p_auto_static) else $error("bmca on in auto");
	property p_ptp_off;
		!PTP_EN_I |=> !ptp_sync && !dly_valid;
	endproperty
	a_ptp_off: assert property (p_ptp_off) else $error("ptp active while off");
endmodule

// [tb/tsp_host_model.sv]
// tsp_host_model: far side of the time pins, satellite receiver and mark source.
// assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
module tsp_host_model #(
	parameter int GAP_CYC = 20	// shortest legal mark spacing
) (
	input  wire logic        clk_i,		// system clock
	output logic             sat_pps_o,	// receiver pulse pin
	output logic             sat_valid_o,	// receiver time valid
	output logic [31:0]      sat_sec_o,	// second at the edge
	output logic             tmark_o		// time mark pin
);
	int cyc;
	int pps_cyc;
	int mark_cyc;

	initial begin
		sat_pps_o = 1'b0;
		sat_valid_o = 1'b0;
		sat_sec_o = 32'h0;
		tmark_o = 1'b0;
		cyc = 0;
		pps_cyc = 0;
		mark_cyc = -1000;
	end

	// pins fall on their own at the 4th rising edge after being set, so callers may watch meanwhile
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (sat_pps_o && cyc - pps_cyc >= 3) begin
			sat_pps_o <= 1'b0;
			sat_sec_o <= ~sat_sec_o;	// hold time over: no stale second
		end
		if (tmark_o && cyc - mark_cyc >= 3) begin
			tmark_o <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// stimulus tasks
	// ----------------------------------------------------------------
	task automatic sat_edge(input logic [31:0] s);
		sat_sec_o = s;
		sat_valid_o = 1'b1;
		sat_pps_o = 1'b1;	// pulse taken from the primary receiver
		pps_cyc = cyc;
	endtask

	task automatic hold_valid(input logic v);
		sat_valid_o = v;
	endtask

	// fast is only set by a scenario that breaks the spacing on purpose
	task automatic mark_pulse(input bit fast);
		if (!fast && cyc - mark_cyc <= GAP_CYC) begin
			while (cyc - mark_cyc <= GAP_CYC) @(posedge clk_i);
			#10;
		end
		tmark_o = 1'b1;
		mark_cyc = cyc;
	endtask
endmodule

// [tb/tsp_time_sync_tb.sv]
// tsp_time_sync_tb: self-checking bench of the time sync block.
// assumes shortened second of 100 cycles, pulse 10, mark gap 20.
`timescale 1ns/1ps
module tsp_time_sync_tb;
	localparam int CYC = 100;
	localparam int GAP = 20;
	logic SYS_CLK_I, RST_I, SAT_PPS_I, SAT_VALID_I, NET_UP_I, ITS_SET_I, TMARK_I;
	logic NTP_EN_I, NTP_REQ_I, PTP_EN_I, PTP_DELAY_REQ_I;
	logic [1:0] PTP_PROFILE_I, TIME_SRC_O;
	logic [31:0] SAT_SEC_I, ITS_SEC_I, TIME_SEC_O, PPS_TS_SEC_O, MARK_TS_SEC_O;
	logic [31:0] NTP_ANS_SEC_O, PTP_SYNC_SEC_O, PTP_DELAY_SEC_O;
	logic [23:0] TIME_SUB_O, MARK_TS_SUB_O, NTP_ANS_SUB_O, PTP_DELAY_SUB_O;
	logic [15:0] RAW_PORT_O, NTP_PORT_O;
	logic HOLDOVER_O, ITS_REQ_O, PPS_O, PPS_TS_VALID_O, MARK_TS_VALID_O, MARK_DROP_O;
	logic NTP_ANS_VALID_O, PTP_SYNC_O, PTP_DELAY_RESP_O, PTP_BMCA_EN_O;
	logic GRAND_MASTER_ROLE_O;
	int num_errors;
	int n_compared;

	tsp_time_sync #(.CYC_PER_SEC(24'(CYC)), .PULSE_CYC(24'h0a), .MARK_GAP_CYC(24'(GAP))) dut_u (
		.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .SAT_PPS_I(SAT_PPS_I),
		.SAT_VALID_I(SAT_VALID_I), .SAT_SEC_I(SAT_SEC_I), .NET_UP_I(NET_UP_I),
		.ITS_SET_I(ITS_SET_I), .ITS_SEC_I(ITS_SEC_I), .TMARK_I(TMARK_I),
		.NTP_EN_I(NTP_EN_I), .NTP_REQ_I(NTP_REQ_I), .PTP_EN_I(PTP_EN_I),
		.PTP_PROFILE_I(PTP_PROFILE_I), .PTP_DELAY_REQ_I(PTP_DELAY_REQ_I),
		.TIME_SRC_O(TIME_SRC_O), .HOLDOVER_O(HOLDOVER_O), .TIME_SEC_O(TIME_SEC_O),
		.TIME_SUB_O(TIME_SUB_O), .ITS_REQ_O(ITS_REQ_O), .PPS_O(PPS_O),
		.PPS_TS_VALID_O(PPS_TS_VALID_O), .PPS_TS_SEC_O(PPS_TS_SEC_O),
		.MARK_TS_VALID_O(MARK_TS_VALID_O), .MARK_TS_SEC_O(MARK_TS_SEC_O),
		.MARK_TS_SUB_O(MARK_TS_SUB_O), .MARK_DROP_O(MARK_DROP_O),
		.RAW_PORT_O(RAW_PORT_O), .NTP_PORT_O(NTP_PORT_O),
		.NTP_ANS_VALID_O(NTP_ANS_VALID_O), .NTP_ANS_SEC_O(NTP_ANS_SEC_O),
		.NTP_ANS_SUB_O(NTP_ANS_SUB_O), .PTP_SYNC_O(PTP_SYNC_O),
		.PTP_SYNC_SEC_O(PTP_SYNC_SEC_O), .PTP_DELAY_RESP_O(PTP_DELAY_RESP_O),
		.PTP_DELAY_SEC_O(PTP_DELAY_SEC_O), .PTP_DELAY_SUB_O(PTP_DELAY_SUB_O),
		.PTP_BMCA_EN_O(PTP_BMCA_EN_O), .GRAND_MASTER_ROLE_O(GRAND_MASTER_ROLE_O));

	tsp_host_model hm_u (.clk_i(SYS_CLK_I), .sat_pps_o(SAT_PPS_I),
		.sat_valid_o(SAT_VALID_I), .sat_sec_o(SAT_SEC_I), .tmark_o(TMARK_I));

	initial begin
		SYS_CLK_I = 1'b0;
		forever #50 SYS_CLK_I = ~SYS_CLK_I;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic chk_b(input string nm, input logic e, input logic g);
		chk_w(nm, 32'(e), 32'(g));
	endtask

	task automatic tick;
		@(posedge SYS_CLK_I);
		#10;
	endtask

	// n = cycles until the next pulse timestamp, bounded
	task automatic wait_pps(output int n);
		n = 0;
		do begin
			tick();
			n++;
		end while (PPS_TS_VALID_O !== 1'b1 && n < 300);
		if (n >= 300) begin
			num_errors++;
			$display("MISMATCH pps wait expected pulse seen none");
			conclude();
		end
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_free;
		int n;
		chk_w("src", 32'h0, 32'(TIME_SRC_O));
		chk_w("ntp port", 32'h7b, 32'(NTP_PORT_O));
		chk_w("raw port", 32'h4e2a, 32'(RAW_PORT_O));
		wait_pps(n);
		wait_pps(n);
		chk_w("pps period", CYC, n);
		n = 0;
		while (PPS_O === 1'b1 && n < 200) begin
			n++;
			tick();
		end
		chk_w("pps high", 10, n);
		NTP_EN_I = 1'b1;
		NTP_REQ_I = 1'b1;
		tick();
		NTP_REQ_I = 1'b0;
		chk_b("ntp ans", 1'b0, NTP_ANS_VALID_O);
		chk_b("its req", 1'b0, ITS_REQ_O);
		$display("test free done");
	endtask

	task automatic t_its;
		NET_UP_I = 1'b1;
		tick();
		tick();
		chk_b("its req", 1'b1, ITS_REQ_O);
		ITS_SET_I = 1'b1;
		ITS_SEC_I = 32'h100;
		tick();
		ITS_SET_I = 1'b0;
		chk_w("src", 32'h1, 32'(TIME_SRC_O));
		chk_w("sec", 32'h100, TIME_SEC_O);
		NTP_REQ_I = 1'b1;
		tick();
		NTP_REQ_I = 1'b0;
		chk_b("ntp ans", 1'b1, NTP_ANS_VALID_O);
		chk_w("ntp sec", 32'h100, NTP_ANS_SEC_O);
		chk_b("its req", 1'b0, ITS_REQ_O);
		chk_w("ntp sub", 32'h0, 32'(NTP_ANS_SUB_O));
		tick();
		NTP_EN_I = 1'b0;
		NTP_REQ_I = 1'b1;
		tick();
		NTP_REQ_I = 1'b0;
		chk_b("ntp off", 1'b0, NTP_ANS_VALID_O);
		$display("test its done");
	endtask

	task automatic t_ptp;
		int n;
		PTP_EN_I = 1'b1;
		for (int p = 0; p < 4; p++) begin
			PTP_PROFILE_I = 2'(p);
			tick();
			chk_b("gm role", p != 3, GRAND_MASTER_ROLE_O);
			chk_b("bmca", p == 1, PTP_BMCA_EN_O);
			PTP_DELAY_REQ_I = 1'b1;
			tick();
			PTP_DELAY_REQ_I = 1'b0;
			chk_b("delay resp", p == 0, PTP_DELAY_RESP_O);
			if (p == 0) begin
				chk_w("delay sec", 32'h100, PTP_DELAY_SEC_O);
				chk_w("delay sub", 32'h4, 32'(PTP_DELAY_SUB_O));
			end
			wait_pps(n);
			chk_b("sync", p != 3, PTP_SYNC_O);
		end
		PTP_PROFILE_I = 2'h1;
		PTP_EN_I = 1'b0;
		tick();
		chk_b("gm off", 1'b0, GRAND_MASTER_ROLE_O);
		chk_b("bmca off", 1'b0, PTP_BMCA_EN_O);
		PTP_EN_I = 1'b1;
		$display("test ptp done");
	endtask

	task automatic t_sat;
		int n;
		wait_pps(n);
		repeat (50) tick();
		hm_u.sat_edge(32'h1234);
		n = 0;
		do begin
			tick();
			n++;
		end while (PPS_TS_VALID_O !== 1'b1 && n < 8);
		chk_w("sat lag", 3, n);
		chk_w("pps sec", 32'h1234, PPS_TS_SEC_O);
		chk_w("src", 32'h2, 32'(TIME_SRC_O));
		ITS_SET_I = 1'b1;
		ITS_SEC_I = 32'h55;
		tick();
		ITS_SET_I = 1'b0;
		tick();
		chk_w("sec kept", 32'h1234, TIME_SEC_O);
		chk_w("sub run", 32'h2, 32'(TIME_SUB_O));
		hm_u.hold_valid(1'b0);
		tick();
		tick();
		chk_b("holdover", 1'b1, HOLDOVER_O);
		wait_pps(n);
		chk_w("hold period", CYC - 4, n);
		chk_w("hold sec", 32'h1235, PPS_TS_SEC_O);
		chk_b("hold sync", 1'b1, PTP_SYNC_O);
		chk_w("sync sec", 32'h1235, PTP_SYNC_SEC_O);
		$display("test sat done");
	endtask

	task automatic t_mark;
		int n;
		logic d;
		logic v;
		wait_pps(n);
		hm_u.mark_pulse(1'b0);
		n = 0;
		do begin
			tick();
			n++;
		end while (MARK_TS_VALID_O !== 1'b1 && n < 8);
		chk_w("mark lag", 3, n);
		chk_w("mark sec", 32'h1236, MARK_TS_SEC_O);
		chk_w("mark sub", 32'h2, 32'(MARK_TS_SUB_O));
		tick();
		tick();
		hm_u.mark_pulse(1'b1);
		d = 1'b0;
		v = 1'b0;
		repeat (8) begin
			tick();
			d = d | MARK_DROP_O;
			v = v | MARK_TS_VALID_O;
		end
		chk_b("mark drop", 1'b1, d);
		chk_b("fast stamp", 1'b0, v);
		hm_u.mark_pulse(1'b0);
		v = 1'b0;
		repeat (8) begin
			tick();
			v = v | MARK_TS_VALID_O;
		end
		chk_b("mark again", 1'b1, v);
		$display("test mark done");
	endtask

	// mid-run reset: time restarts free from zero, no stub pulse
	task automatic t_reset;
		int n;
		NET_UP_I = 1'b1;
		RST_I = 1'b1;
		tick();
		chk_w("rst sec", 32'h0, TIME_SEC_O);
		chk_b("rst pps", 1'b0, PPS_O);
		RST_I = 1'b0;
		tick();
		chk_w("rst src", 32'h0, 32'(TIME_SRC_O));
		chk_w("rst sub", 32'h1, 32'(TIME_SUB_O));
		chk_b("no stub", 1'b0, PPS_TS_VALID_O);
		chk_b("its req", 1'b1, ITS_REQ_O);
		NET_UP_I = 1'b0;
		tick();
		chk_b("net down", 1'b0, ITS_REQ_O);
		wait_pps(n);
		chk_w("first pps", CYC - 2, n);
		chk_w("first sec", 32'h1, PPS_TS_SEC_O);
		$display("test reset done");
	endtask

	initial begin
		num_errors = 0;
		n_compared = 0;
		RST_I = 1'b1;
		NET_UP_I = 1'b0;
		ITS_SET_I = 1'b0;
		ITS_SEC_I = 32'h0;
		NTP_EN_I = 1'b0;
		NTP_REQ_I = 1'b0;
		PTP_EN_I = 1'b0;
		PTP_PROFILE_I = 2'h0;
		PTP_DELAY_REQ_I = 1'b0;
		repeat (3) @(posedge SYS_CLK_I);
		#10;
		RST_I = 1'b0;
		t_free();
		t_its();
		t_ptp();
		t_sat();
		t_mark();
		t_reset();
		conclude();
	end
endmodule
